// File: rtl/itd_pkg.sv
// Purpose: Shared constants and types for the instruction timing decoder.
// Assumes: 14-bit instruction words, 8-bit file registers, four clocks per instruction cycle.
// Notes: Opcode patterns compare only the defined bits of each format.
package itd_pkg;

  typedef logic [13:0] itd_word_t;

  // Instruction cycle phases, one clock each
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_READ = 2'h1;
  localparam logic [1:0] PHASE_EVAL = 2'h2;
  localparam logic [1:0] PHASE_WRITE = 2'h3;

  // Instruction cycle counts
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;

  // Field positions
  localparam int F_DEST = 7;
  localparam int F_PTR_LONG = 6;
  localparam int F_PTR_SHORT = 2;

  // Format group in bits 13:12
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;

  // Literal and control patterns
  localparam logic [2:0] OP_CALL = 3'h4;        // bits 13:11
  localparam logic [2:0] OP_ABS_JUMP = 3'h5;    // bits 13:11
  localparam logic [3:0] OP_EXIT_LIT = 4'hD;    // bits 13:10
  localparam logic [4:0] OP_REL_JUMP = 5'h19;   // bits 13:9
  localparam logic [6:0] OP_PTR_ADD = 7'h62;    // bits 13:7
  localparam logic [5:0] OP_PTR_OFS = 6'h3F;    // bits 13:8
  // Control group: bits 13:7 zero, code in bits 6:0
  localparam logic [6:0] CTL_GROUP = 7'h00;
  localparam logic [6:0] CTL_RETURN = 7'h08;
  localparam logic [6:0] CTL_INT_EXIT = 7'h09;
  localparam logic [6:0] CTL_INVOKE_ACC = 7'h0A;
  localparam logic [6:0] CTL_JUMP_ACC = 7'h0B;
  localparam logic [2:0] CTL_PTR_MOVE = 3'h1;   // bits 6:4

  // Byte-oriented patterns in bits 13:8 / 13:7
  localparam logic [5:0] OP_DEC_SKIP = 6'h0B;
  localparam logic [5:0] OP_INC_SKIP = 6'h0F;
  localparam logic [6:0] OP_STORE_ACC = 7'h01;
  localparam logic [6:0] OP_CLEAR_FILE = 7'h03;

  // Bit-oriented operation in bits 11:10
  localparam logic [1:0] BOP_CLEAR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_SKIP_ZERO = 2'h2;
  localparam logic [1:0] BOP_SKIP_ONE = 2'h3;

  // Indirect access ports in file space
  localparam logic [6:0] ADDR_PORT0 = 7'h00;
  localparam logic [6:0] ADDR_PORT1 = 7'h01;
  localparam logic [6:0] ADDR_MAX = 7'h7F;

  // Skip conditions on the read value
  localparam logic [7:0] DEC_HITS_ZERO = 8'h01;
  localparam logic [7:0] INC_HITS_ZERO = 8'hFF;

  typedef enum logic [1:0] {CAT_BYTE, CAT_BIT, CAT_LIT_CTL} itd_cat_e;

  // Pointer update mode, two bits
  typedef enum logic [1:0] {PM_PRE_INC, PM_PRE_DEC, PM_POST_INC, PM_POST_DEC} itd_pmode_e;

  typedef enum logic [2:0] {
    SK_NONE, SK_BIT_ONE, SK_BIT_ZERO, SK_DEC_ZERO, SK_INC_ZERO
  } itd_skip_e;

  typedef struct packed {
    itd_cat_e category;
    logic dest_file;
    logic [6:0] file_addr;
    logic [2:0] bit_sel;
    logic [7:0] bit_mask;
    logic ptr_sel;
    itd_pmode_e ptr_mode;
    logic uses_file;
    logic indirect;
    logic writes_file;
    logic writes_acc;
    itd_skip_e skip;
  } itd_decode_s;

endpackage

// File: rtl/itd_phase_gen.sv
// Purpose: Divides the oscillator clock into the four phases of an instruction cycle.
// Assumes: Single clock domain.
// Notes: cycle_start_out is a one-clock enable at the first phase.
`timescale 1ns/100ps
`default_nettype none
module itd_phase_gen (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Phase outputs
  output logic [1:0] phase_out,
  output logic cycle_start_out
);
  import itd_pkg::*;

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      phase_out <= PHASE_LAST;
    end else begin
      phase_out <= phase_out + 2'h1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cycle_start_out <= 1'b0;
    end else begin
      cycle_start_out <= (phase_out == PHASE_LAST);
    end
  end
endmodule
`default_nettype wire

// File: rtl/itd_decoder.sv
// Purpose: Decode 14-bit instruction words and sequence their instruction cycles.
// Assumes: Next word stable on instr_word_in at each cycle start; file data valid in phase 2.
// Notes: Skips and program-memory indirect access stretch the instruction by whole cycles.
`timescale 1ns/100ps
`default_nettype none
module itd_decoder (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Program memory side
  input wire itd_pkg::itd_word_t instr_word_in,
  output logic fetch_out,
  // Pointer state, one bit per pointer: high when it addresses program memory
  input wire logic [1:0] ptr_prog_in,
  // Data file side
  input wire logic [7:0] file_rdata_in,
  output logic file_rd_out,
  output logic file_wr_out,
  output logic acc_wr_out,
  // Decode and timing status
  output var itd_pkg::itd_decode_s decode_out,
  output logic [1:0] cycles_out,
  output logic exec_out,
  output logic flush_out
);
  import itd_pkg::*;

  typedef enum {CY_EXEC, CY_EXTRA, CY_FLUSH} itd_cycle_e;

  logic [1:0] phase;
  logic cycle_start;
  itd_cycle_e cycle_kind;
  logic [1:0] remaining;
  logic skip_pend;
  itd_decode_s next_decode;
  logic [1:0] next_cycles;
  logic skip_hit;
  logic take_new;

  itd_phase_gen u_phase (
    .ref_clk_in(ref_clk_in),
    .rst_b_in(rst_b_in),
    .phase_out(phase),
    .cycle_start_out(cycle_start)
  );

  // Decode of the word presented at the cycle start
  always_comb begin
    next_decode = '0;
    next_cycles = CYC_ONE;
    next_decode.dest_file = instr_word_in[F_DEST];
    next_decode.file_addr = instr_word_in[6:0] & ADDR_MAX;
    next_decode.bit_sel = instr_word_in[9:7];
    next_decode.bit_mask = 8'h01 << instr_word_in[9:7];
    next_decode.ptr_sel = instr_word_in[F_PTR_LONG];
    next_decode.ptr_mode = itd_pmode_e'(instr_word_in[1:0]);
    // Bits outside each format's defined fields are never compared
    case (instr_word_in[13:12])
      GRP_BYTE: begin
        if (instr_word_in[13:7] == CTL_GROUP) begin
          next_decode.category = CAT_LIT_CTL;
          next_decode.dest_file = 1'b0;
          if (instr_word_in[6:4] == CTL_PTR_MOVE) begin
            next_decode.indirect = 1'b1;
            next_decode.ptr_sel = instr_word_in[F_PTR_SHORT];
          end
          case (instr_word_in[6:0])
            CTL_RETURN, CTL_INT_EXIT: next_cycles = CYC_TWO;
            CTL_INVOKE_ACC: next_cycles = CYC_TWO;
            CTL_JUMP_ACC: next_cycles = CYC_TWO;
            default: next_cycles = CYC_ONE;
          endcase
        end else begin
          next_decode.category = CAT_BYTE;
          next_decode.uses_file = 1'b1;
          if (instr_word_in[13:7] == OP_STORE_ACC || instr_word_in[13:7] == OP_CLEAR_FILE) begin
            next_decode.dest_file = 1'b1;
          end
          next_decode.writes_file = next_decode.dest_file;
          next_decode.writes_acc = !next_decode.dest_file;
          if (instr_word_in[13:8] == OP_DEC_SKIP) begin
            next_decode.skip = SK_DEC_ZERO;
          end else if (instr_word_in[13:8] == OP_INC_SKIP) begin
            next_decode.skip = SK_INC_ZERO;
          end
        end
      end
      GRP_BIT: begin
        next_decode.category = CAT_BIT;
        next_decode.uses_file = 1'b1;
        next_decode.dest_file = 1'b1;
        case (instr_word_in[11:10])
          BOP_CLEAR, BOP_SET: next_decode.writes_file = 1'b1;
          BOP_SKIP_ZERO: next_decode.skip = SK_BIT_ZERO;
          BOP_SKIP_ONE: next_decode.skip = SK_BIT_ONE;
          default: next_decode.skip = SK_NONE;
        endcase
      end
      default: begin
        next_decode.category = CAT_LIT_CTL;
        next_decode.dest_file = 1'b0;
        if (instr_word_in[13:11] == OP_CALL) begin
          next_cycles = CYC_TWO;
        end else if (instr_word_in[13:11] == OP_ABS_JUMP) begin
          next_cycles = CYC_TWO;
        end else if (instr_word_in[13:10] == OP_EXIT_LIT) begin
          next_cycles = CYC_TWO;
        end else if (instr_word_in[13:9] == OP_REL_JUMP) begin
          next_cycles = CYC_TWO;
        end else if (instr_word_in[13:8] == OP_PTR_OFS) begin
          next_decode.indirect = 1'b1;
        end else if (instr_word_in[13:7] == OP_PTR_ADD) begin
          next_decode.indirect = 1'b0;
        end
      end
    endcase
    // Direct naming of an access port is an indirect access through its pointer
    if (next_decode.uses_file &&
        (next_decode.file_addr == ADDR_PORT0 || next_decode.file_addr == ADDR_PORT1)) begin
      next_decode.indirect = 1'b1;
      next_decode.ptr_sel = next_decode.file_addr[0];
    end
    if (next_decode.indirect && ptr_prog_in[next_decode.ptr_sel]) begin
      next_cycles = next_cycles + CYC_ONE;
    end
  end

  // Skip condition on the file data present in phase 2
  always_comb begin
    case (decode_out.skip)
      SK_BIT_ONE: skip_hit = file_rdata_in[decode_out.bit_sel];
      SK_BIT_ZERO: skip_hit = !file_rdata_in[decode_out.bit_sel];
      SK_DEC_ZERO: skip_hit = (file_rdata_in == DEC_HITS_ZERO);
      SK_INC_ZERO: skip_hit = (file_rdata_in == INC_HITS_ZERO);
      default: skip_hit = 1'b0;
    endcase
  end

  assign take_new = cycle_start && (remaining == 2'h0);

  // Instruction latch, taken only when the previous one has used all its cycles
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      decode_out <= '0;
      cycles_out <= 2'h0;
    end else if (take_new) begin
      decode_out <= next_decode;
      cycles_out <= next_cycles;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fetch_out <= 1'b0;
    end else begin
      fetch_out <= take_new;
    end
  end

  // Cycle sequencing: remaining counts cycles still owed after the current one
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cycle_kind <= CY_EXTRA;
      remaining <= 2'h0;
      skip_pend <= 1'b0;
    end else if (take_new) begin
      cycle_kind <= CY_EXEC;
      remaining <= next_cycles - CYC_ONE;
      skip_pend <= 1'b0;
    end else if (cycle_start) begin
      cycle_kind <= skip_pend ? CY_FLUSH : CY_EXTRA;
      remaining <= remaining - 2'h1;
      skip_pend <= 1'b0;
    end else if (cycle_kind == CY_EXEC && phase == PHASE_EVAL && skip_hit) begin
      // A taken skip owes one discard cycle; the untaken case adds no cycle
      remaining <= remaining + 2'h1;
      skip_pend <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      exec_out <= 1'b0;
      flush_out <= 1'b0;
    end else begin
      exec_out <= (cycle_kind == CY_EXEC);
      flush_out <= (cycle_kind == CY_FLUSH);
    end
  end

  // Read in phase 1 even for write-only forms, store in phase 3
  always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      file_rd_out <= 1'b0;
      file_wr_out <= 1'b0;
      acc_wr_out <= 1'b0;
    end else begin
      // Raised on the take edge so the pulse lands in phase 1 of the new instruction
      file_rd_out <= take_new && (phase == PHASE_READ - 2'h1)
                     && next_decode.uses_file;
      file_wr_out <= (cycle_kind == CY_EXEC) && (phase == PHASE_WRITE - 2'h1)
                     && decode_out.writes_file;
      acc_wr_out <= (cycle_kind == CY_EXEC) && (phase == PHASE_WRITE - 2'h1)
                    && decode_out.writes_acc;
    end
  end
endmodule
`default_nettype wire

// File: tb/itd_decoder_sva.sv
// Purpose: Port-level timing and routing checks for the instruction timing decoder.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Spacing checks count clocks between fetch pulses.
`timescale 1ns/100ps
`default_nettype none
module itd_decoder_sva (
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_b_in,
  // Watched decoder outputs
  input wire logic fetch_out,
  input wire logic file_rd_out,
  input wire logic file_wr_out,
  input wire logic acc_wr_out,
  input wire itd_pkg::itd_decode_s decode_out,
  input wire logic [1:0] cycles_out,
  input wire logic exec_out,
  input wire logic flush_out
);
  import itd_pkg::*;
  logic plain_op;
  // Skips are left out here: their length depends on the data read
  assign plain_op = fetch_out && decode_out.skip == SK_NONE;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_b_in);
  sequence quiet3;
    !fetch_out [*3];
  endsequence
  sequence quiet7;
    !fetch_out [*7];
  endsequence
  chk_fetch_gap: assert property (fetch_out |=> quiet3)
    else $error("fetch pulses closer than one instruction cycle");
  chk_one_cycle: assert property (plain_op && cycles_out == CYC_ONE |=> quiet3 ##1 fetch_out)
    else $error("single-cycle instruction not four clocks long");
  chk_two_cycle: assert property (plain_op && cycles_out == CYC_TWO |=> quiet7 ##1 fetch_out)
    else $error("two-cycle instruction not eight clocks long");
  chk_exec_follow: assert property (fetch_out |=> exec_out)
    else $error("execute cycle did not follow fetch");
  chk_read_first: assert property (file_wr_out |-> $past(file_rd_out, 2))
    else $error("file store without a read two clocks before");
  chk_read_pulse: assert property (file_rd_out |-> decode_out.uses_file ##1 !file_rd_out)
    else $error("file read not a single pulse for a file operand");
  chk_dest_acc: assert property (acc_wr_out && decode_out.category == CAT_BYTE |-> !decode_out.dest_file)
    else $error("accumulator written while destination selects file");
  chk_bit_mask: assert property (fetch_out && decode_out.category == CAT_BIT |-> $onehot(decode_out.bit_mask) && decode_out.bit_mask[decode_out.bit_sel])
    else $error("bit mask does not match bit number");
  chk_flush_len: assert property ($rose(flush_out) |-> flush_out [*4] ##1 !flush_out)
    else $error("discard cycle not four clocks long");
endmodule
bind itd_decoder itd_decoder_sva u_sva (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
  .fetch_out(fetch_out), .file_rd_out(file_rd_out), .file_wr_out(file_wr_out),
  .acc_wr_out(acc_wr_out), .decode_out(decode_out), .cycles_out(cycles_out),
  .exec_out(exec_out), .flush_out(flush_out));
`default_nettype wire

// File: tb/itd_file_model.sv
// Purpose: Data file space seen by the decoder's read port.
// Assumes: Bench preloads mem by hierarchical write before use.
// Notes: Outside an access the bus moves every clock, so stale data never matches.
`timescale 1ns/100ps
`default_nettype none
module itd_file_model (
  // Clock
  input wire logic ref_clk_in,
  // Access qualifiers
  input wire logic file_rd_in,
  input wire logic exec_in,
  input wire logic [6:0] addr_in,
  // Read data
  output logic [7:0] rdata_out
);
  logic [7:0] mem [0:127];
  logic [7:0] last = 8'h5A;
  always @(posedge ref_clk_in) last <= rdata_out;
  assign rdata_out = (exec_in || file_rd_in) ? mem[addr_in] : ~last;
  initial begin
    foreach (mem[k]) mem[k] = 8'h00;
  end
endmodule
`default_nettype wire

// File: tb/test_instruction_timing_decoder.sv
// Purpose: Self-checking bench for decode fields and instruction cycle spacing.
// Assumes: A word is taken at a cycle start; the next word goes out after fetch.
// Notes: Spacing is checked as four clocks per expected instruction cycle.
`timescale 1ns/100ps
`default_nettype none
module test_instruction_timing_decoder;
  import itd_pkg::*;
  typedef struct {logic [1:0] cyc; int n; itd_cat_e cat; int sel; logic [7:0] fx;} itd_exp_s;
  logic ref_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  itd_word_t instr_word = 14'h0000;
  logic [1:0] ptr_prog = 2'h0;
  logic [7:0] rdata;
  logic fetch, rd, wr, acc_wr, exec, flush;
  itd_decode_s dec;
  logic [1:0] cyc;
  itd_exp_s q[$];
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'hd6d6;
  always #25 ref_clk_in = ~ref_clk_in;
  itd_decoder dut (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .instr_word_in(instr_word),
    .fetch_out(fetch), .ptr_prog_in(ptr_prog), .file_rdata_in(rdata), .file_rd_out(rd),
    .file_wr_out(wr), .acc_wr_out(acc_wr), .decode_out(dec), .cycles_out(cyc),
    .exec_out(exec), .flush_out(flush));
  itd_file_model u_file (.ref_clk_in(ref_clk_in), .file_rd_in(rd), .exec_in(exec),
    .addr_in(dec.file_addr), .rdata_out(rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("Comparisons %0d, errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input itd_word_t w, input logic [1:0] p, input logic [1:0] c, input int n,
                      input itd_cat_e ct, input int s, input logic [7:0] x);
    int i;
    q.push_back('{c, n, ct, s, x});
    instr_word <= w;
    ptr_prog <= p;
    for (i = 0; i < 60; i++) begin
      @(posedge ref_clk_in);
      if (fetch === 1'b1) break;
    end
    if (i == 60) begin
      error_cnt++;
      results();
    end
  endtask
  // Compares each decode against the oldest note and the gap since the last fetch
  initial begin : mon
    itd_exp_s e;
    int t;
    int last_t;
    int last_n;
    int last_c;
    int fl;
    int nw;
    int na;
    logic [1:0] last_wa;
    t = 0;
    last_t = 0;
    last_n = 0;
    last_c = 0;
    fl = 0;
    nw = 0;
    na = 0;
    last_wa = 2'h0;
    forever begin
      @(posedge ref_clk_in);
      #1;
      t++;
      // Pulses of one instruction are counted up to and including the next fetch sample
      fl += int'(flush === 1'b1);
      nw += int'(wr === 1'b1);
      na += int'(acc_wr === 1'b1);
      if (fetch === 1'b1) begin
        chk(q.size() > 0, 1'b1);
        if (q.size() > 0) begin
          e = q.pop_front();
          chk(rd, e.cat != CAT_LIT_CTL);
          if (last_n > 0) begin
            chk(t - last_t, 4 * last_n);
            chk(fl, 4 * (last_n - last_c));
            chk(nw, last_wa[1]);
            chk(na, last_wa[0]);
          end
          last_c = e.cyc;
          last_wa = (e.sel == 1) ? {e.fx[7], !e.fx[7]} : 2'h0;
          fl = 0;
          nw = 0;
          na = 0;
          chk(cyc, e.cyc);
          chk(dec.category, e.cat);
          if (e.sel == 1) chk({dec.dest_file, dec.file_addr}, e.fx);
          if (e.sel == 2) chk({dec.ptr_sel, dec.ptr_mode}, e.fx);
          if (e.sel == 3) chk(dec.bit_sel, e.fx);
          last_t = t;
          last_n = e.n;
        end
      end
    end
  end
  initial begin
    int i;
    logic [6:0] f;
    logic d;
    itd_word_t ctl [8];
    ctl = '{14'h2000, 14'h000A, 14'h0008, 14'h3400, 14'h0009, 14'h2800, 14'h3200, 14'h000B};
    repeat (5) @(posedge ref_clk_in);
    rst_b_in <= 1'b1;
    foreach (ctl[k]) send(ctl[k], 2'h0, CYC_TWO, 2, CAT_LIT_CTL, 0, 8'h00);
    send(14'h0720, 2'h3, CYC_ONE, 1, CAT_BYTE, 1, 8'h20);
    send(14'h07FF, 2'h3, CYC_ONE, 1, CAT_BYTE, 1, 8'hFF);
    for (i = 0; i < 6; i++) begin
      f = 7'({$random(seed)} % 126 + 2);
      d = 1'($random(seed));
      send({6'h07, d, f}, 2'($random(seed)), CYC_ONE, 1, CAT_BYTE, 1, {d, f});
    end
    // Access ports: only the pointer that addresses program memory costs a cycle
    send(14'h0780, 2'h1, CYC_TWO, 2, CAT_BYTE, 1, 8'h80);
    send(14'h0781, 2'h1, CYC_ONE, 1, CAT_BYTE, 1, 8'h81);
    send(14'h0701, 2'h2, CYC_TWO, 2, CAT_BYTE, 1, 8'h01);
    for (i = 0; i < 4; i++) send(14'h0014 | 14'(i), 2'h2, CYC_TWO, 2, CAT_LIT_CTL, 2, 8'(4 + i));
    for (i = 0; i < 8; i++) begin
      u_file.mem[64 + i] = 8'h01 << i;
      send(14'h1C40 | 14'(i << 7) | 14'(i), 2'h0, CYC_ONE, 2, CAT_BIT, 3, 8'(i));
      send(14'h1840 | 14'(i << 7) | 14'(i), 2'h0, CYC_ONE, 1, CAT_BIT, 3, 8'(i));
    end
    u_file.mem[80] = 8'h01;
    u_file.mem[81] = 8'h02;
    u_file.mem[82] = 8'hFF;
    u_file.mem[83] = 8'h00;
    send(14'h0BD0, 2'h0, CYC_ONE, 2, CAT_BYTE, 1, 8'hD0);
    send(14'h0BD1, 2'h0, CYC_ONE, 1, CAT_BYTE, 1, 8'hD1);
    send(14'h0FD2, 2'h0, CYC_ONE, 2, CAT_BYTE, 1, 8'hD2);
    send(14'h0FD3, 2'h0, CYC_ONE, 1, CAT_BYTE, 1, 8'hD3);
    send(14'h00A0, 2'h0, CYC_ONE, 1, CAT_BYTE, 1, 8'hA0);
    send(14'h01A0, 2'h0, CYC_ONE, 1, CAT_BYTE, 1, 8'hA0);
    send(14'h3F40, 2'h2, CYC_TWO, 2, CAT_LIT_CTL, 0, 8'h00);
    repeat (2) send(14'h0000, 2'h0, CYC_ONE, 1, CAT_LIT_CTL, 0, 8'h00);
    // The decoder keeps taking words; stop before the next fetch finds no note
    repeat (2) @(posedge ref_clk_in);
    chk(q.size(), 0);
    results();
  end
endmodule
`default_nettype wire
